// *** wbdmu_move_unit.sv ***
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module wbdmu_move_unit
   import wbdmu_pkg::*;
(
   // Clock, reset and enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Built-in input and external output pins
   input wire logic [WORD_W-1:0] builtin_in,
   output logic [WORD_W-1:0] ext_out,
   // Status
   output wbdmu_flags_t flags,
   output logic irq
);
   import wbdmu_pkg::*;

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   // Flags of a word move: zero and sign of what lands in the destination
   function automatic wbdmu_flags_t word_flags(input logic [31:0] val, input logic wide);
      wbdmu_flags_t f;
      f.error = 1'b0;
      f.zero = wide ? (val == 32'h0000_0000) : (val[15:0] == 16'h0000);
      f.neg = wide ? val[31] : val[15];
      return f;
   endfunction

   // Missing byte lanes write zero rather than keep old contents
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // State and registers
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DRIVE} wbdmu_state_t;

   wbdmu_state_t state_r;
   wbdmu_state_t state_nxt;
   logic [7:0] cmd_r;
   logic [WORD_W-1:0] src_lo_r;
   logic [WORD_W-1:0] src_hi_r;
   logic [WORD_W-1:0] ctrl_r;
   logic [WORD_W-1:0] dst_lo_r;
   logic [WORD_W-1:0] dst_hi_r;
   logic [WORD_W-1:0] snap_r;
   logic [WORD_W-1:0] ext_out_r;
   logic [IRQ_W-1:0] int_stat_r;
   logic [IRQ_W-1:0] int_en_r;
   wbdmu_flags_t flags_r;
   logic [WORD_W-1:0] in_meta_r;
   logic [WORD_W-1:0] in_sync_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_r;

   // ----------------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------------
   // Two stages before any logic sees the pins; costs two cycles of latency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_meta_r <= RESET_WORD;
         in_sync_r <= RESET_WORD;
      end else if (clk_en) begin
         in_meta_r <= builtin_in;
         in_sync_r <= in_meta_r;
      end
   end

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   // Zero wait states: the answer always follows the setup cycle by one clock
   wire setup = psel && !penable;
   wire wr_take = psel && penable && pready_r && pwrite;
   wire busy = (state_r != ST_IDLE);

   wire hit_cmd = (paddr == CMD_OFF);
   wire hit_src_lo = (paddr == SRC_LO_OFF);
   wire hit_src_hi = (paddr == SRC_HI_OFF);
   wire hit_ctrl = (paddr == CTRL_OFF);
   wire hit_dst_lo = (paddr == DST_LO_OFF);
   wire hit_dst_hi = (paddr == DST_HI_OFF);
   wire hit_flags = (paddr == FLAGS_OFF);
   wire hit_stat = (paddr == INT_STAT_OFF);
   wire hit_en = (paddr == INT_EN_OFF);
   wire hit_clr = (paddr == INT_CLR_OFF);
   wire hit_snap = (paddr == IN_SNAP_OFF);
   wire hit_ext = (paddr == EXT_OUT_OFF);
   wire hit_status = (paddr == STATUS_OFF);
   wire hit_any = hit_cmd || hit_src_lo || hit_src_hi || hit_ctrl || hit_dst_lo
      || hit_dst_hi || hit_flags || hit_stat || hit_en || hit_clr || hit_snap
      || hit_ext || hit_status;
   // Read-only targets refuse writes; write-only clear reads as zero
   wire ro_hit = hit_flags || hit_stat || hit_snap || hit_status;
   // Operand writes while an operation runs would corrupt it, so they are refused
   wire busy_hit = busy && (hit_cmd || hit_src_lo || hit_src_hi || hit_ctrl
      || hit_dst_lo || hit_dst_hi || hit_ext);
   wire req_err = !hit_any || (pwrite && (ro_hit || busy_hit));

   wire [31:0] rd_mux =
      hit_cmd ? {24'h00_0000, cmd_r} :
      hit_src_lo ? {16'h0000, src_lo_r} :
      hit_src_hi ? {16'h0000, src_hi_r} :
      hit_ctrl ? {16'h0000, ctrl_r} :
      hit_dst_lo ? {16'h0000, dst_lo_r} :
      hit_dst_hi ? {16'h0000, dst_hi_r} :
      hit_flags ? {29'h0000_0000, flags_r} :
      hit_stat ? {30'h0000_0000, int_stat_r} :
      hit_en ? {30'h0000_0000, int_en_r} :
      hit_snap ? {16'h0000, snap_r} :
      hit_ext ? {16'h0000, ext_out_r} :
      hit_status ? {31'h0000_0000, busy} :
      RESET_BUS;

   wire wr_ok = wr_take && !pslverr_r;
   wire [31:0] wr_val = lane_merge(RESET_BUS, pwdata, pstrb);
   wire start = wr_ok && hit_cmd;

   // ----------------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------------
   wire [CMD_OP_W-1:0] op = cmd_r[CMD_OP_LSB +: CMD_OP_W];
   wire src_from_in = cmd_r[CMD_SRC_IN_BIT];
   wire dst_to_out = cmd_r[CMD_DST_OUT_BIT];

   // Refresh copy reads the freshly synchronised pins, not the old snapshot
   wire [WORD_W-1:0] word_src = (op == OP_WORD_IMM && src_from_in) ? in_sync_r : src_lo_r;

   // Positions are range-checked on the full byte; only the low nibble indexes
   wire [7:0] bit_n = ctrl_r[7:0];
   wire [7:0] bit_m = ctrl_r[15:8];
   wire bit_err = (bit_n > 8'(BIT_POS_MAX)) || (bit_m > 8'(BIT_POS_MAX));
   wire bit_val = src_lo_r[bit_n[3:0]];

   logic [WORD_W-1:0] bit_result;
   always_comb begin
      bit_result = dst_lo_r;
      bit_result[bit_m[3:0]] = bit_val;
   end

   logic [WORD_W-1:0] nib_result;
   logic nib_err;

   wbdmu_nibble_mover u_nib (
      .src(src_lo_r),
      .dst(dst_lo_r),
      .ctrl(ctrl_r),
      .result(nib_result),
      .err(nib_err)
   );

   // Result of the operation held in cmd_r
   logic [WORD_W-1:0] res_lo;
   logic [WORD_W-1:0] res_hi;
   wbdmu_flags_t res_flags;
   logic res_err;
   always_comb begin
      res_lo = dst_lo_r;
      res_hi = dst_hi_r;
      res_flags = flags_r;
      res_err = 1'b0;
      case (op)
         OP_WORD, OP_WORD_IMM: begin
            res_lo = word_src;
            res_flags = word_flags({16'h0000, word_src}, 1'b0);
         end
         OP_DWORD: begin
            res_lo = src_lo_r;
            res_hi = src_hi_r;
            res_flags = word_flags({src_hi_r, src_lo_r}, 1'b1);
         end
         OP_INV: begin
            res_lo = ~src_lo_r;
            res_flags = word_flags({16'h0000, ~src_lo_r}, 1'b0);
         end
         OP_BIT: begin
            // On a bad position the destination is left alone
            res_lo = bit_err ? dst_lo_r : bit_result;
            res_flags.error = bit_err;
            res_err = bit_err;
         end
         OP_NIBBLE: begin
            // Any bad control digit leaves the whole destination word alone
            res_lo = nib_err ? dst_lo_r : nib_result;
            res_flags.error = nib_err;
            res_err = nib_err;
         end
         default: begin
            // Unused codes are flagged, not ignored, so software notices them
            res_flags.error = 1'b1;
            res_err = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   // One operation at a time; software polls busy or waits for the done event
   // Pins sampled in EXEC, outputs driven in DRIVE: input before, output after
   always_comb begin
      case (state_r)
         ST_IDLE: state_nxt = start ? ST_EXEC : ST_IDLE;
         ST_EXEC: state_nxt = ST_DRIVE;
         ST_DRIVE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   wire exec = (state_r == ST_EXEC);
   wire drive = (state_r == ST_DRIVE);
   wire [IRQ_W-1:0] ev_set = {exec && res_err, exec};
   wire [IRQ_W-1:0] ev_clr = (wr_ok && hit_clr) ? wr_val[IRQ_W-1:0] : {IRQ_W{1'b0}};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         flags_r <= FLAGS_RESET;
         snap_r <= RESET_WORD;
      end else if (clk_en) begin
         state_r <= state_nxt;
         if (exec) begin
            flags_r <= res_flags;
            snap_r <= in_sync_r;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_r <= 8'h00;
         src_lo_r <= RESET_WORD;
         src_hi_r <= RESET_WORD;
         ctrl_r <= RESET_WORD;
         int_en_r <= {IRQ_W{1'b0}};
      end else if (clk_en && wr_ok) begin
         if (hit_cmd) cmd_r <= wr_val[7:0];
         if (hit_src_lo) src_lo_r <= wr_val[WORD_W-1:0];
         if (hit_src_hi) src_hi_r <= wr_val[WORD_W-1:0];
         if (hit_ctrl) ctrl_r <= wr_val[WORD_W-1:0];
         if (hit_en) int_en_r <= wr_val[IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dst_lo_r <= RESET_WORD;
         dst_hi_r <= RESET_WORD;
         ext_out_r <= RESET_WORD;
      end else if (clk_en) begin
         // Datapath result has priority; operand writes are refused while busy
         if (exec) begin
            dst_lo_r <= res_lo;
            dst_hi_r <= res_hi;
         end else if (wr_ok && hit_dst_lo) begin
            dst_lo_r <= wr_val[WORD_W-1:0];
         end else if (wr_ok && hit_dst_hi) begin
            dst_hi_r <= wr_val[WORD_W-1:0];
         end
         if (drive && op == OP_WORD_IMM && dst_to_out) begin
            ext_out_r <= dst_lo_r;
         end else if (wr_ok && hit_ext) begin
            ext_out_r <= wr_val[WORD_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Interrupts and bus answer
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= {IRQ_W{1'b0}};
         irq_r <= 1'b0;
         prdata_r <= RESET_BUS;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else if (clk_en) begin
         // A new event wins over a clear in the same cycle
         int_stat_r <= (int_stat_r & ~ev_clr) | ev_set;
         // Built from the next status value so irq rises in the same clock as its status bit
         irq_r <= |(((int_stat_r & ~ev_clr) | ev_set) & int_en_r);
         // Ready stands for exactly the first access cycle
         pready_r <= setup;
         pslverr_r <= setup && req_err;
         if (setup && !pwrite) begin
            prdata_r <= rd_mux;
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign ext_out = ext_out_r;
   assign flags = flags_r;
   assign irq = irq_r;
endmodule

// *** wbdmu_nibble_mover.sv ***
// ----------------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------------
package wbdmu_pkg;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned ADDR_W = 12;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] CMD_OFF = 12'h000;
   localparam logic [ADDR_W-1:0] SRC_LO_OFF = 12'h004;
   localparam logic [ADDR_W-1:0] SRC_HI_OFF = 12'h008;
   localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h00c;
   localparam logic [ADDR_W-1:0] DST_LO_OFF = 12'h010;
   localparam logic [ADDR_W-1:0] DST_HI_OFF = 12'h014;
   localparam logic [ADDR_W-1:0] FLAGS_OFF = 12'h018;
   localparam logic [ADDR_W-1:0] INT_STAT_OFF = 12'h01c;
   localparam logic [ADDR_W-1:0] INT_EN_OFF = 12'h020;
   localparam logic [ADDR_W-1:0] INT_CLR_OFF = 12'h024;
   localparam logic [ADDR_W-1:0] IN_SNAP_OFF = 12'h028;
   localparam logic [ADDR_W-1:0] EXT_OUT_OFF = 12'h02c;
   localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h030;

   // Command register fields
   localparam int unsigned CMD_OP_LSB = 0;
   localparam int unsigned CMD_OP_W = 3;
   localparam int unsigned CMD_SRC_IN_BIT = 3;
   localparam int unsigned CMD_DST_OUT_BIT = 4;

   // Operation codes
   localparam logic [CMD_OP_W-1:0] OP_WORD = 3'h0;
   localparam logic [CMD_OP_W-1:0] OP_DWORD = 3'h1;
   localparam logic [CMD_OP_W-1:0] OP_INV = 3'h2;
   localparam logic [CMD_OP_W-1:0] OP_BIT = 3'h3;
   localparam logic [CMD_OP_W-1:0] OP_NIBBLE = 3'h4;
   localparam logic [CMD_OP_W-1:0] OP_WORD_IMM = 3'h5;

   // Control-word layout
   localparam int unsigned BIT_POS_MAX = 15;
   localparam int unsigned NIB_MAX = 3;
   localparam int unsigned NIB_COUNT = 4;

   // Interrupt status bit positions
   localparam int unsigned IRQ_DONE_BIT = 0;
   localparam int unsigned IRQ_ERR_BIT = 1;
   localparam int unsigned IRQ_W = 2;

   localparam logic [WORD_W-1:0] RESET_WORD = 16'h0000;
   localparam logic [31:0] RESET_BUS = 32'h0000_0000;

   typedef struct packed {
      logic neg;
      logic zero;
      logic error;
   } wbdmu_flags_t;

   localparam wbdmu_flags_t FLAGS_RESET = '{neg: 1'b0, zero: 1'b0, error: 1'b0};
endpackage

`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Four-digit copy with wrap-around
// ----------------------------------------------------------------------
module wbdmu_nibble_mover
   import wbdmu_pkg::*;
(
   // Operands
   input wire logic [WORD_W-1:0] src,
   input wire logic [WORD_W-1:0] dst,
   input wire logic [WORD_W-1:0] ctrl,
   // Result
   output logic [WORD_W-1:0] result,
   output logic err
);
   // Digit fields of the control word
   wire [3:0] src_start = ctrl[3:0];
   wire [3:0] cnt_m1 = ctrl[7:4];
   wire [3:0] dst_start = ctrl[11:8];

   assign err = (src_start > 4'(NIB_MAX)) || (cnt_m1 > 4'(NIB_MAX))
      || (dst_start > 4'(NIB_MAX));

   always_comb begin
      logic [1:0] si;
      logic [1:0] di;
      si = src_start[1:0];
      di = dst_start[1:0];
      result = dst;
      for (int i = 0; i < NIB_COUNT; i++) begin
         if (2'(i) <= cnt_m1[1:0]) begin
            // Index counters are two bits wide so stepping past 3 wraps to 0
            result[di*4 +: 4] = src[si*4 +: 4];
            si = si + 2'd1;
            di = di + 2'd1;
         end
      end
   end
endmodule

// *** wbdmu_move_checker.sv ***
`timescale 1ns/100ps
module wbdmu_move_checker
   import wbdmu_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wbdmu_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Results
   input wire logic [wbdmu_pkg::WORD_W-1:0] ext_out,
   input wire wbdmu_pkg::wbdmu_flags_t flags
);
   import wbdmu_pkg::*;
   logic acc;
   logic cmd;
   logic bit_bad;
   logic nib_bad;
   logic [15:0] src_r;
   logic [15:0] hi_r;
   logic [15:0] ctrl_r;
   assign acc = psel && penable && pready && pwrite && !pslverr && clk_en;
   assign cmd = acc && paddr == CMD_OFF;
   assign bit_bad = ctrl_r[7:0] > 8'h0f || ctrl_r[15:8] > 8'h0f;
   assign nib_bad = ctrl_r[3:0] > 4'h3 || ctrl_r[7:4] > 4'h3 || ctrl_r[11:8] > 4'h3;
   // Operands seen on the bus; refused writes never land, so they stay valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_r <= 16'h0000;
         hi_r <= 16'h0000;
         ctrl_r <= 16'h0000;
      end else if (acc) begin
         if (paddr == SRC_LO_OFF) src_r <= pwdata[15:0];
         if (paddr == SRC_HI_OFF) hi_r <= pwdata[15:0];
         if (paddr == CTRL_OFF) ctrl_r <= pwdata[15:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_word_zero: assert property (cmd && pwdata[2:0] == OP_WORD |-> ##2
      (flags.zero == (src_r == 16'h0000) && !flags.error)) else $error("word zero flag");
   a_word_neg: assert property (cmd && pwdata[2:0] == OP_WORD |-> ##2
      flags.neg == src_r[15]) else $error("word negative flag");
   a_inv_flags: assert property (cmd && pwdata[2:0] == OP_INV |-> ##2
      (flags.zero == (src_r == 16'hffff) && flags.neg == !src_r[15])) else $error("inv flags");
   a_dword_flags: assert property (cmd && pwdata[2:0] == OP_DWORD |-> ##2
      (flags.zero == ({hi_r, src_r} == 32'h0) && flags.neg == hi_r[15])) else $error("dword flags");
   a_bit_error: assert property (cmd && pwdata[2:0] == OP_BIT |-> ##2
      flags.error == bit_bad) else $error("bit copy error flag");
   a_nib_error: assert property (cmd && pwdata[2:0] == OP_NIBBLE |-> ##2
      flags.error == nib_bad) else $error("digit copy error flag");
   a_bit_keeps: assert property (cmd && pwdata[2:0] == OP_BIT |=>
      ($stable(flags.zero) && $stable(flags.neg)) [*6]) else $error("bit copy moved flags");
   a_refresh_out: assert property (cmd && pwdata[2:0] == OP_WORD_IMM && pwdata[4] &&
      !pwdata[3] |-> ##3 ext_out == src_r) else $error("refresh output");
endmodule

bind wbdmu_move_unit wbdmu_move_checker u_chk (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .ext_out(ext_out), .flags(flags));

// *** wbdmu_move_unit_tb.sv ***
`timescale 1ns/100ps
module wbdmu_move_unit_tb;
   import wbdmu_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [WORD_W-1:0] builtin_in = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [WORD_W-1:0] ext_out;
   wbdmu_flags_t flags;
   logic [31:0] q;
   logic e;
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   always #4 pclk = ~pclk;
   wbdmu_move_unit DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .builtin_in(builtin_in),
      .ext_out(ext_out), .flags(flags), .irq(irq));
   task test_done;
      if (miscompares == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Bound on the whole run; well under a thousand cycles are expected
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         test_done;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task idle;
      do begin
         apb(1'b0, STATUS_OFF, 32'h0);
      end while (q[0] !== 1'b0);
   endtask
   task op(input logic [31:0] c, input logic [15:0] s, h, k, d, x, xh, input logic [2:0] f);
      apb(1'b1, SRC_LO_OFF, {16'h0, s});
      apb(1'b1, SRC_HI_OFF, {16'h0, h});
      apb(1'b1, CTRL_OFF, {16'h0, k});
      apb(1'b1, DST_LO_OFF, {16'h0, d});
      apb(1'b1, DST_HI_OFF, 32'h0);
      apb(1'b1, CMD_OFF, c);
      idle;
      apb(1'b0, DST_LO_OFF, 32'h0);
      chk(q, {16'h0, x});
      apb(1'b0, DST_HI_OFF, 32'h0);
      chk(q, {16'h0, xh});
      chk({29'h0, flags}, {29'h0, f});
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      chk({29'h0, flags}, 32'h0);
      op(OP_BIT, 16'h0020, 0, 16'h1005, 16'h0, 16'h0, 0, 3'b001);
      apb(1'b0, INT_STAT_OFF, 32'h0);
      chk(q, 32'h3);
      chk({31'h0, irq}, 32'h0);
      op(OP_WORD, 16'h0000, 0, 0, 16'h5a5a, 16'h0000, 0, 3'b010);
      op(OP_BIT, 16'h0020, 0, 16'h0c05, 16'h0, 16'h1000, 0, 3'b010);
      op(OP_BIT, 16'h0000, 0, 16'h000f, 16'hffff, 16'hfffe, 0, 3'b010);
      op(OP_BIT, 16'h0001, 0, 16'h0f00, 16'h0001, 16'h8001, 0, 3'b010);
      op(OP_BIT, 16'hffff, 0, 16'h0510, 16'h1234, 16'h1234, 0, 3'b011);
      op(OP_WORD, 16'h8000, 0, 0, 16'h0, 16'h8000, 0, 3'b100);
      op(OP_INV, 16'hffff, 0, 0, 16'h1, 16'h0000, 0, 3'b010);
      op(OP_INV, 16'h1234, 0, 0, 16'h0, 16'hedcb, 0, 3'b100);
      apb(1'b0, SRC_LO_OFF, 32'h0);
      chk(q, 32'h1234);
      op(OP_DWORD, 16'h0000, 16'h8001, 0, 16'h7, 16'h0000, 16'h8001, 3'b100);
      op(OP_DWORD, 16'h0001, 16'h0000, 0, 16'h7, 16'h0001, 16'h0000, 3'b000);
      op(OP_DWORD, 16'h0000, 16'h0000, 0, 16'h7, 16'h0000, 16'h0000, 3'b010);
      op(OP_NIBBLE, 16'h4321, 0, 16'h0031, 16'h0, 16'h1432, 0, 3'b010);
      op(OP_NIBBLE, 16'h4321, 0, 16'h0133, 16'h0, 16'h2143, 0, 3'b010);
      op(OP_NIBBLE, 16'ha000, 0, 16'h0303, 16'h1111, 16'ha111, 0, 3'b010);
      op(OP_NIBBLE, 16'h4321, 0, 16'h0004, 16'h5555, 16'h5555, 0, 3'b011);
      op(OP_NIBBLE, 16'h4321, 0, 16'h0040, 16'h5555, 16'h5555, 0, 3'b011);
      op(OP_NIBBLE, 16'h4321, 0, 16'h0400, 16'h5555, 16'h5555, 0, 3'b011);
      op(OP_NIBBLE, 16'h0007, 0, 16'h3000, 16'hfff0, 16'hfff7, 0, 3'b010);
      apb(1'b1, INT_CLR_OFF, 32'h3);
      apb(1'b1, INT_EN_OFF, 32'h1);
      builtin_in <= 16'hbeef;
      op(32'h1d, 16'h0, 0, 0, 16'h0, 16'hbeef, 0, 3'b100);
      chk({16'h0, ext_out}, 32'hbeef);
      chk({31'h0, irq}, 32'h1);
      op(32'h15, 16'h0, 0, 0, 16'h1, 16'h0000, 0, 3'b010);
      chk({16'h0, ext_out}, 32'h0);
      op(32'h05, 16'h0123, 0, 0, 16'h0, 16'h0123, 0, 3'b000);
      chk({16'h0, ext_out}, 32'h0);
      apb(1'b1, INT_CLR_OFF, 32'h3);
      apb(1'b0, INT_STAT_OFF, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // Refused accesses: unmapped place and a read-only register
      apb(1'b0, 12'h100, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, FLAGS_OFF, 32'h7);
      chk({31'h0, e}, 32'h1);
      chk({29'h0, flags}, 32'h0);
      test_done;
   end
endmodule
